/* File: hw/cdc_map.svh */
`ifndef CDC_MAP_SVH
`define CDC_MAP_SVH
// How it works
// - each up-count event below the upper limit with no down event in the same sample adds exactly one to the count value
// - comparison output goes high when count lies in the configured range
// - coincidence pulses the external output via set/reset latch and raises interrupt
// - up events come from CW/CCW or one/two-phase addition pulses
// - down events come from CCW pulses on b, a rising while b is high (also an up event, so the count holds), or two-phase multiple-of-one subtraction pulses
// - coincidence result is forwarded as an event to another counter block
// - 32-bit variant uses a cam-switch threshold path for coincidence
// - interrupt issued at most once per 50 us; repeats inside are dropped

// ----------------------------------------
// register offsets
// ----------------------------------------
`define CDC_CTRL_OFS 12'h000
`define CDC_UPPER_OFS 12'h004
`define CDC_LOWER_OFS 12'h008
`define CDC_CMPA_OFS 12'h00C
`define CDC_CMPB_OFS 12'h010
`define CDC_COUNT_OFS 12'h014
`define CDC_STAT_OFS 12'h018
`define CDC_IEN_OFS 12'h01C
`define CDC_ICLR_OFS 12'h020

// ----------------------------------------
// control fields
// ----------------------------------------
`define CDC_CTRL_EN 0
`define CDC_CTRL_RING 1
`define CDC_CTRL_ADDSEL 2
`define CDC_CTRL_SUBSEL 3
`define CDC_CTRL_MODEA_LSB 4
`define CDC_CTRL_MODEB_LSB 6
`define CDC_CTRL_CAM 8
`define CDC_CTRL_CLR 9

// ----------------------------------------
// status bits, resets, timing
// ----------------------------------------
`define CDC_ST_MATCH 0
`define CDC_ST_IRQDROP 1
`define CDC_NSTAT 2
`define CDC_UPPER_RST 32'h0000_07D0
`define CDC_CMP_RST 32'h0000_03E8
`define CDC_SAMPLE_NS 25
`define CDC_CLK_NS 10
`define CDC_IRQ_GAP_NS 50000
`define CDC_SAMPLE_CYC ((`CDC_SAMPLE_NS + `CDC_CLK_NS - 1) / `CDC_CLK_NS)
`define CDC_IRQ_GAP_CYC ((`CDC_IRQ_GAP_NS + `CDC_CLK_NS - 1) / `CDC_CLK_NS)
`endif

/* File: hw/cdc_pkg.sv */
package cdc_pkg;
  typedef enum logic [1:0] {
    CDC_CMP_EQ = 2'h0,
    CDC_CMP_GE = 2'h1,
    CDC_CMP_LE = 2'h2,
    CDC_CMP_OFF = 2'h3
  } cdc_cmp_e;
endpackage

/* File: hw/cdc_evt_if.sv */
`timescale 1ns/1ps
interface cdc_evt_if;
  logic up;
  logic down;
  modport src (output up, output down);
  modport dst (input up, input down);
endinterface

/* File: hw/cdc_edge_det.sv */
`timescale 1ns/1ps
`include "cdc_map.svh"
module cdc_edge_det import cdc_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic smp_en,
  input wire logic in_a,
  input wire logic in_b,
  input wire logic add_sel,
  input wire logic sub_sel,
  cdc_evt_if.src evt
);
  logic a_q;
  logic b_q;
  logic rise_a;
  logic fall_a;
  logic rise_b;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_q <= 1'b0;
      b_q <= 1'b0;
    end else if (smp_en) begin
      a_q <= in_a;
      b_q <= in_b;
    end
  end

  assign rise_a = smp_en && in_a && !a_q;
  assign fall_a = smp_en && !in_a && a_q;
  assign rise_b = smp_en && in_b && !b_q;

  // add_sel 0: cw pulses on a, ccw on b; 1: two-phase a leads b
  assign evt.up = add_sel ? (rise_a && !in_b) : rise_a;
  assign evt.down = add_sel ? (fall_a && !in_b) : (sub_sel ? (rise_a && in_b) : rise_b);
endmodule // cdc_edge_det

/* File: hw/cdc_irq_gap.sv */
`timescale 1ns/1ps
`include "cdc_map.svh"
module cdc_irq_gap #(
  parameter int GAP_CYC = `CDC_IRQ_GAP_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic req,
  output logic fire,
  output logic drop
);
  logic [15:0] cnt_q;

  // one request per window, repeats dropped
  assign fire = req && (cnt_q == 16'h0000);
  assign drop = req && (cnt_q != 16'h0000);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= 16'h0000;
    end else if (fire) begin
      cnt_q <= 16'(GAP_CYC - 1);
    end else if (cnt_q != 16'h0000) begin
      cnt_q <= cnt_q - 16'h0001;
    end
  end
endmodule // cdc_irq_gap

/* File: hw/cdc_top.sv */
// Local design decisions: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`include "cdc_map.svh"
module cdc_top import cdc_pkg::*; #(
  parameter int IRQ_GAP_CYC = `CDC_IRQ_GAP_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic pulse_a,
  input wire logic pulse_b,
  output logic ext_out,
  output logic cmp_out,
  output logic evt_out,
  output logic irq
);
  // ----------------------------------------
  // bus slave
  // ----------------------------------------
  logic wr_pend_q;
  logic [11:0] wr_addr_q;
  logic [31:0] ctrl_q;
  logic [31:0] upper_q;
  logic [31:0] lower_q;
  logic [31:0] cmpa_q;
  logic [31:0] cmpb_q;
  logic [31:0] count_q;
  logic [`CDC_NSTAT-1:0] stat_q;
  logic [`CDC_NSTAT-1:0] ien_q;
  logic [`CDC_NSTAT-1:0] clr_w;
  logic addr_ok;
  logic [31:0] rd_d;

  assign addr_ok = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 12'h000;
    end else begin
      wr_pend_q <= addr_ok && hwrite;
      wr_addr_q <= haddr;
    end
  end

  always_comb begin
    rd_d = 32'h0000_0000;
    unique case (haddr)
      `CDC_CTRL_OFS: rd_d = ctrl_q;
      `CDC_UPPER_OFS: rd_d = upper_q;
      `CDC_LOWER_OFS: rd_d = lower_q;
      `CDC_CMPA_OFS: rd_d = cmpa_q;
      `CDC_CMPB_OFS: rd_d = cmpb_q;
      `CDC_COUNT_OFS: rd_d = count_q;
      `CDC_STAT_OFS: rd_d = {{(32-`CDC_NSTAT){1'b0}}, stat_q};
      `CDC_IEN_OFS: rd_d = {{(32-`CDC_NSTAT){1'b0}}, ien_q};
      default: rd_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (addr_ok && !hwrite) begin
      hrdata <= rd_d;
    end
  end

  // software configures modes and values before enabling
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= 32'h0000_0000;
      upper_q <= `CDC_UPPER_RST;
      lower_q <= 32'h0000_0000;
      cmpa_q <= `CDC_CMP_RST;
      cmpb_q <= `CDC_CMP_RST;
      ien_q <= '0;
    end else if (wr_pend_q) begin
      unique case (wr_addr_q)
        `CDC_CTRL_OFS: ctrl_q <= hwdata;
        `CDC_UPPER_OFS: upper_q <= hwdata;
        `CDC_LOWER_OFS: lower_q <= hwdata;
        `CDC_CMPA_OFS: cmpa_q <= hwdata;
        `CDC_CMPB_OFS: cmpb_q <= hwdata;
        `CDC_IEN_OFS: ien_q <= hwdata[`CDC_NSTAT-1:0];
        default: ;
      endcase
    end
  end

  assign clr_w = (wr_pend_q && wr_addr_q == `CDC_ICLR_OFS) ? hwdata[`CDC_NSTAT-1:0] : '0;

  // ----------------------------------------
  // sampling enable
  // ----------------------------------------
  logic [3:0] smp_cnt_q;
  logic smp_en;

  // 30 ns sample tick
  assign smp_en = (smp_cnt_q == 4'(`CDC_SAMPLE_CYC - 1));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      smp_cnt_q <= 4'h0;
    end else if (smp_en) begin
      smp_cnt_q <= 4'h0;
    end else begin
      smp_cnt_q <= smp_cnt_q + 4'h1;
    end
  end

  // ----------------------------------------
  // edge detect and counter
  // ----------------------------------------
  cdc_evt_if evt ();

  cdc_edge_det u_edge (
    .hclk(hclk),
    .hresetn(hresetn),
    .smp_en(smp_en),
    .in_a(pulse_a),
    .in_b(pulse_b),
    .add_sel(ctrl_q[`CDC_CTRL_ADDSEL]),
    .sub_sel(ctrl_q[`CDC_CTRL_SUBSEL]),
    .evt(evt.src)
  );

  logic run;
  logic ring;
  assign run = ctrl_q[`CDC_CTRL_EN];
  assign ring = ctrl_q[`CDC_CTRL_RING];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_q <= 32'h0000_0000;
    end else if (wr_pend_q && wr_addr_q == `CDC_CTRL_OFS && hwdata[`CDC_CTRL_CLR]) begin
      count_q <= lower_q;
    end else if (run && evt.up && !evt.down) begin
      if (count_q >= upper_q) begin
        count_q <= ring ? lower_q : upper_q;
      end else begin
        count_q <= count_q + 32'h0000_0001;
      end
    end else if (run && evt.down && !evt.up) begin
      if (count_q <= lower_q) begin
        count_q <= ring ? upper_q : lower_q;
      end else begin
        count_q <= count_q - 32'h0000_0001;
      end
    end
  end

  // ----------------------------------------
  // range compare
  // ----------------------------------------
  function automatic logic cmp_fn(input logic [1:0] m, input logic [31:0] c, input logic [31:0] v);
    unique case (m)
      2'h0: cmp_fn = (c == v);
      2'h1: cmp_fn = (c >= v);
      2'h2: cmp_fn = (c <= v);
      default: cmp_fn = 1'b1;
    endcase
  endfunction

  logic hit16;
  logic hit32;
  logic hit;
  logic hit_q;
  assign hit16 = cmp_fn(ctrl_q[`CDC_CTRL_MODEA_LSB+:2], {16'h0000, count_q[15:0]}, {16'h0000, cmpa_q[15:0]})
    && cmp_fn(ctrl_q[`CDC_CTRL_MODEB_LSB+:2], {16'h0000, count_q[15:0]}, {16'h0000, cmpb_q[15:0]});
  // cam-switch style threshold on full width
  assign hit32 = (count_q >= cmpa_q) && (count_q <= cmpb_q);
  assign hit = run && (ctrl_q[`CDC_CTRL_CAM] ? hit32 : hit16);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hit_q <= 1'b0;
      cmp_out <= 1'b0;
      evt_out <= 1'b0;
    end else begin
      hit_q <= hit;
      cmp_out <= hit;
      evt_out <= hit && !hit_q;
    end
  end

  // set/reset latch: set on new match, reset next cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_out <= 1'b0;
    end else if (hit && !hit_q) begin
      ext_out <= 1'b1;
    end else begin
      ext_out <= 1'b0;
    end
  end

  // ----------------------------------------
  // interrupts
  // ----------------------------------------
  logic fire;
  logic drop;

  cdc_irq_gap #(.GAP_CYC(IRQ_GAP_CYC)) u_gap (
    .hclk(hclk),
    .hresetn(hresetn),
    .req(hit && !hit_q),
    .fire(fire),
    .drop(drop)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_q <= '0;
      irq <= 1'b0;
    end else begin
      stat_q[`CDC_ST_MATCH] <= fire | (stat_q[`CDC_ST_MATCH] & ~clr_w[`CDC_ST_MATCH]);
      stat_q[`CDC_ST_IRQDROP] <= drop | (stat_q[`CDC_ST_IRQDROP] & ~clr_w[`CDC_ST_IRQDROP]);
      irq <= |(stat_q & ien_q);
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  count_step_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (run && evt.up && !evt.down && count_q < upper_q && !wr_pend_q) |=> count_q == $past(count_q) + 32'h1)
    else $error("count did not step by one");
  ring_wrap_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (run && ring && evt.up && !evt.down && count_q >= upper_q && !wr_pend_q) |=> count_q == $past(lower_q))
    else $error("ring wrap failed");
  cmp_follow_a: assert property (@(posedge hclk) disable iff (!hresetn)
    hit |=> cmp_out) else $error("compare output missing");
  ext_pulse_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ext_out |=> !ext_out) else $error("output pulse too long");
  evt_fwd_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (hit && !hit_q) |=> evt_out && ext_out) else $error("event not forwarded");
  irq_gap_a: assert property (@(posedge hclk) disable iff (!hresetn)
    fire |=> !fire [*8]) else $error("interrupt repeated in window");
  smp_tick_a: assert property (@(posedge hclk) disable iff (!hresetn)
    smp_en |=> !smp_en ##1 !smp_en ##1 smp_en) else $error("sample tick wrong");
  match_sticky_a: assert property (@(posedge hclk) disable iff (!hresetn)
    fire |=> stat_q[`CDC_ST_MATCH]) else $error("match status not set");

  // ----------------------------------------
  // check helpers
  // ----------------------------------------
  logic [15:0] since_fire_q;

  // cycles since last granted interrupt, saturating
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      since_fire_q <= '1;
    end else if (fire) begin
      since_fire_q <= 16'h0000;
    end else if (since_fire_q != 16'hFFFF) begin
      since_fire_q <= since_fire_q + 16'h0001;
    end
  end

  // ----------------------------------------
  // checks: counter
  // ----------------------------------------
  count_down_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (run && evt.down && !evt.up && count_q > lower_q && !wr_pend_q) |=> count_q == $past(count_q) - 32'h1)
    else $error("count did not step down by one");
  ring_down_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (run && ring && evt.down && !evt.up && count_q <= lower_q && !wr_pend_q) |=> count_q == $past(upper_q))
    else $error("ring wrap down failed");
  sat_upper_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (run && !ring && evt.up && !evt.down && count_q >= upper_q && !wr_pend_q) |=> count_q == $past(upper_q))
    else $error("linear count passed upper limit");
  sat_lower_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (run && !ring && evt.down && !evt.up && count_q <= lower_q && !wr_pend_q) |=> count_q == $past(lower_q))
    else $error("linear count passed lower limit");
  count_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (!run && !wr_pend_q) |=> count_q == $past(count_q))
    else $error("count moved while stopped");
  up_tick_a: assert property (@(posedge hclk) disable iff (!hresetn)
    evt.up |-> smp_en)
    else $error("up event off the sample tick");
  down_tick_a: assert property (@(posedge hclk) disable iff (!hresetn)
    evt.down |-> smp_en)
    else $error("down event off the sample tick");
  smp_range_a: assert property (@(posedge hclk) disable iff (!hresetn)
    smp_cnt_q <= 4'(`CDC_SAMPLE_CYC - 1))
    else $error("sample divider out of range");

  // ----------------------------------------
  // checks: compare and outputs
  // ----------------------------------------
  cmp_drop_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !hit |=> !cmp_out)
    else $error("compare output stuck high");
  evt_once_a: assert property (@(posedge hclk) disable iff (!hresetn)
    evt_out |=> !evt_out)
    else $error("event pulse too long");
  ext_match_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ext_out |-> cmp_out)
    else $error("output pulse without coincidence");

  // ----------------------------------------
  // checks: interrupts
  // ----------------------------------------
  irq_window_a: assert property (@(posedge hclk) disable iff (!hresetn)
    fire |-> since_fire_q >= 16'(IRQ_GAP_CYC - 1))
    else $error("interrupt inside guard window");
  drop_sticky_a: assert property (@(posedge hclk) disable iff (!hresetn)
    drop |=> stat_q[`CDC_ST_IRQDROP])
    else $error("dropped request not flagged");
  match_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (stat_q[`CDC_ST_MATCH] && !clr_w[`CDC_ST_MATCH]) |=> stat_q[`CDC_ST_MATCH])
    else $error("match status lost");
  irq_on_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (|(stat_q & ien_q)) |=> irq)
    else $error("interrupt not raised");
  irq_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !(|(stat_q & ien_q)) |=> !irq)
    else $error("interrupt raised without cause");

  // ----------------------------------------
  // checks: bus
  // ----------------------------------------
  rd_count_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (addr_ok && !hwrite && haddr == `CDC_COUNT_OFS) |=> hrdata == $past(count_q))
    else $error("count read data wrong");
  reload_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_pend_q && wr_addr_q == `CDC_CTRL_OFS && hwdata[`CDC_CTRL_CLR]) |=> count_q == $past(lower_q))
    else $error("count reload failed");
endmodule // cdc_top

/* File: bench/cdc_pulse_src.sv */
`timescale 1ns/1ps
module cdc_pulse_src (
  input wire logic hclk,
  output logic pulse_a,
  output logic pulse_b
);
  // ----------------------------------------
  // external pulse source
  // ----------------------------------------
  initial begin
    pulse_a = 1'b0;
    pulse_b = 1'b0;
  end
  // each level held 3 clocks so the 30 ns sampler sees it
  task automatic pulse(input logic on_b);
    repeat (3) @(posedge hclk);
    if (on_b) pulse_b <= 1'b1;
    else pulse_a <= 1'b1;
    repeat (3) @(posedge hclk);
    pulse_a <= 1'b0;
    pulse_b <= 1'b0;
  endtask
endmodule  // cdc_pulse_src

/* File: bench/tb.sv */
`timescale 1ns/1ps
`include "cdc_map.svh"
module tb import cdc_pkg::*; ;
  typedef struct packed {logic w; logic [11:0] a; logic [31:0] d;} cdc_row_s;
  localparam logic [31:0] RUN = {24'h0, CDC_CMP_LE, CDC_CMP_GE, 4'h3};
  localparam cdc_row_s ROWS [23] = '{
    '{1'b0, `CDC_CTRL_OFS, 32'h0}, '{1'b0, `CDC_UPPER_OFS, `CDC_UPPER_RST}, '{1'b0, `CDC_LOWER_OFS, 32'h0},
    '{1'b0, `CDC_CMPA_OFS, `CDC_CMP_RST}, '{1'b0, `CDC_CMPB_OFS, `CDC_CMP_RST}, '{1'b0, `CDC_COUNT_OFS, 32'h0},
    '{1'b0, `CDC_STAT_OFS, 32'h0}, '{1'b0, `CDC_IEN_OFS, 32'h0}, '{1'b0, `CDC_ICLR_OFS, 32'h0},
    '{1'b0, 12'h024, 32'h0}, '{1'b1, 12'h024, 32'hFFFF_FFFF}, '{1'b0, 12'h024, 32'h0},
    '{1'b1, `CDC_STAT_OFS, 32'h3}, '{1'b0, `CDC_STAT_OFS, 32'h0}, '{1'b1, `CDC_COUNT_OFS, 32'h5},
    '{1'b0, `CDC_COUNT_OFS, 32'h0}, '{1'b1, `CDC_UPPER_OFS, 32'h14}, '{1'b0, `CDC_UPPER_OFS, 32'h14},
    '{1'b1, `CDC_CMPA_OFS, 32'h5}, '{1'b1, `CDC_CMPB_OFS, 32'h5}, '{1'b0, `CDC_CMPB_OFS, 32'h5},
    '{1'b1, `CDC_IEN_OFS, 32'h1}, '{1'b0, `CDC_IEN_OFS, 32'h1}
  };
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, pulse_a, pulse_b, ext_out, cmp_out, evt_out, irq;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata;
  int err_count, cmp_count, ext_n, evt_n;
  cdc_top #(.IRQ_GAP_CYC(20)) cdc_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pulse_a(pulse_a), .pulse_b(pulse_b), .ext_out(ext_out),
    .cmp_out(cmp_out), .evt_out(evt_out), .irq(irq));
  cdc_pulse_src cdc_pulse_src_i (.hclk(hclk), .pulse_a(pulse_a), .pulse_b(pulse_b));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  always @(posedge hclk) begin
    if (ext_out === 1'b1) ext_n <= ext_n + 1;
    if (evt_out === 1'b1) evt_n <= evt_n + 1;
  end
  task automatic print_verdict;
    $display("checks=%0d errors=%0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      err_count++;
      print_verdict();
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    r = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    check(r, e);
  endtask
  task automatic pul(input logic on_b);
    cdc_pulse_src_i.pulse(on_b);
  endtask
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 12'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (8) @(posedge hclk);
    check({hreadyout, hresp, irq, cmp_out, ext_out, evt_out}, 32'h20);
    hresetn <= 1'b1;
    foreach (ROWS[i]) begin
      if (ROWS[i].w) wr(ROWS[i].a, ROWS[i].d);
      else rd(ROWS[i].a, ROWS[i].d);
    end
    $display("done: registers");
    wr(`CDC_CTRL_OFS, RUN);
    repeat (4) pul(1'b0);
    rd(`CDC_COUNT_OFS, 32'h4);
    check({cmp_out, irq, ext_n[0]}, 32'h0);
    pul(1'b0);
    repeat (4) @(posedge hclk);
    rd(`CDC_COUNT_OFS, 32'h5);
    check({cmp_out, irq}, 32'h3);
    check(ext_n, 32'h1);
    check(evt_n, 32'h1);
    rd(`CDC_STAT_OFS, 32'h1);
    $display("done: coincidence");
    repeat (20) @(posedge hclk);
    wr(`CDC_CMPA_OFS, 32'h0001_0005);
    wr(`CDC_CMPB_OFS, 32'h0001_0005);
    repeat (3) @(posedge hclk);
    check(cmp_out, 32'h1);
    wr(`CDC_CTRL_OFS, RUN | 32'h100);
    repeat (3) @(posedge hclk);
    check(cmp_out, 32'h0);
    wr(`CDC_CMPA_OFS, 32'h5);
    wr(`CDC_CMPB_OFS, 32'h5);
    repeat (3) @(posedge hclk);
    check(cmp_out, 32'h1);
    wr(`CDC_CTRL_OFS, RUN);
    pul(1'b1);
    rd(`CDC_COUNT_OFS, 32'h4);
    $display("done: wide path");
    repeat (25) @(posedge hclk);
    wr(`CDC_ICLR_OFS, 32'h3);
    rd(`CDC_STAT_OFS, 32'h0);
    check(irq, 32'h0);
    pul(1'b0);
    pul(1'b1);
    pul(1'b0);
    repeat (4) @(posedge hclk);
    rd(`CDC_STAT_OFS, 32'h3);
    repeat (25) @(posedge hclk);
    wr(`CDC_ICLR_OFS, 32'h3);
    pul(1'b1);
    pul(1'b0);
    repeat (4) @(posedge hclk);
    rd(`CDC_STAT_OFS, 32'h1);
    $display("done: interrupt spacing");
    wr(`CDC_CTRL_OFS, RUN | 32'h200);
    rd(`CDC_COUNT_OFS, 32'h0);
    pul(1'b1);
    rd(`CDC_COUNT_OFS, 32'h14);
    pul(1'b0);
    rd(`CDC_COUNT_OFS, 32'h0);
    wr(`CDC_CTRL_OFS, RUN & 32'hFFFF_FFFD);
    pul(1'b1);
    rd(`CDC_COUNT_OFS, 32'h0);
    $display("done: ring");
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    check({hreadyout, hresp, irq, cmp_out, ext_out, evt_out}, 32'h20);
    hresetn <= 1'b1;
    rd(`CDC_CTRL_OFS, 32'h0);
    rd(`CDC_UPPER_OFS, `CDC_UPPER_RST);
    $display("done: reset");
    print_verdict();
  end
endmodule  // tb
